// *** logic/fwo_pkg.sv ***
package fwo_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 25;
  localparam int OVP_FILT_NS     = 1000;
  localparam int OTP_FILT_NS     = 2000;
  localparam int OTP_BLANK_NS    = 50000;
  localparam int REM_BLANK_NS    = 100000;
  localparam int AR_TIME_NS      = 100000;
  // round up to whole cycles
  localparam int OVP_FILT_CYC    = (OVP_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OTP_FILT_CYC    = (OTP_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OTP_BLANK_CYC   = (OTP_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REM_BLANK_CYC   = (REM_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AR_TIME_CYC     = (AR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 16;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FILT   = 8'h08;
  localparam logic [7:0] ADDR_BLANK  = 8'h0C;
  localparam logic [7:0] ADDR_ARTIME = 8'h10;
  localparam int         CTRL_RUN_BIT  = 0;
  localparam int         LO_LSB        = 0;
  localparam int         HI_LSB        = 16;
  localparam logic       CTRL_RUN_RST  = 1'b1;
  localparam logic [CNT_W-1:0] OVP_FILT_RST  = CNT_W'(OVP_FILT_CYC);
  localparam logic [CNT_W-1:0] OTP_FILT_RST  = CNT_W'(OTP_FILT_CYC);
  localparam logic [CNT_W-1:0] OTP_BLANK_RST = CNT_W'(OTP_BLANK_CYC);
  localparam logic [CNT_W-1:0] REM_BLANK_RST = CNT_W'(REM_BLANK_CYC);
  localparam logic [CNT_W-1:0] AR_TIME_RST   = CNT_W'(AR_TIME_CYC);

  // ----------------------------------------------------------------
  // sequencer states, gray along idle-run-off-recover-latch
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RUN   = 3'b001,
    ST_OFF   = 3'b011,
    ST_AR    = 3'b010,
    ST_LATCH = 3'b110
  } fwo_state_t;
endpackage

// *** logic/fwo_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
// two flop synchroniser for comparator levels
module fwo_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// *** logic/fwo_filter.sv ***
`timescale 1ns/100ps
`default_nettype none
// confirms a level held for a terminal count of cycles
module fwo_filter
  import fwo_pkg::*;
(
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // level and limit
  input  wire logic             level,
  input  wire logic [CNT_W-1:0] term_cnt,
  output logic                  confirmed
);
  logic [CNT_W-1:0] cnt_q;

  // count while the level stands, restart on any drop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q     <= '0;
      confirmed <= 1'b0;
    end else if (!level) begin
      cnt_q     <= '0;
      confirmed <= 1'b0;
    end else if (cnt_q + CNT_W'(1) >= term_cnt) begin
      confirmed <= 1'b1;
    end else begin
      cnt_q     <= cnt_q + CNT_W'(1);
    end
  end
endmodule
`default_nettype wire

// *** logic/fwo_top.sv ***
// Behaviour
// RULE1 - window between low and high thresholds
// RULE2 - switching only while window holds
// RULE3 - stop only after filter delay expires
// RULE4 - latch or auto-recovery per strap
// RULE5 - separate filters for high and low
// RULE6 - ignore low comparator during startup blanking
// RULE7 - doubled sense current while blanking startup
// RULE8 - protect enable on five restart events; the code sets it on three: start, bulk flag rise in run, skip exit
// RULE9 - sense current off on five events
// RULE10 - latched: no pulses, supply cycles
// RULE11 - latch cleared only by reset level
// RULE12 - overvoltage needs strong external pull-up
// RULE13 - active-on: remote input only off-mode
// RULE14 - enter off-mode above entry level
// RULE15 - leave off-mode below exit level
// RULE16 - secondary holds opto active to run
// RULE17 - blanking pulls remote input low
// RULE18 - blank on turn-on except normal off-exit
// RULE19 - blank at first start and recovery
// RULE20 - no blanking for no-load cycling
// RULE21 - off-mode uses self-supply cycling
// RULE22 - bulk flag high means run allowed
// RULE23 - synced inputs, counter filters, timers
// RULE24 - variant straps sampled at reset only
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module fwo_top
  import fwo_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // comparator levels
  input  wire logic        window_protect_above_high,
  input  wire logic        window_protect_below_low,
  input  wire logic        supply_above_turn_on,
  input  wire logic        supply_below_turn_off,
  input  wire logic        supply_below_reset,
  input  wire logic        bulk_in_range_flag,
  input  wire logic        skip_entry_reached,
  input  wire logic        skip_exit_reached,
  input  wire logic        remote_above_entry,
  input  wire logic        remote_below_exit,
  // variant straps
  input  wire logic        strap_latched,
  input  wire logic        strap_active_on,
  // control outputs
  output logic             switch_enable,
  output logic             protect_enable_signal,
  output logic             sense_current_enable,
  output logic             doubled_sense_current,
  output logic             remote_pull_low,
  output logic             self_supply_cycling,
  output logic             latched_fault,
  output logic             offmode_active
);
  // ----------------------------------------------------------------
  // input synchronisers and filters
  // ----------------------------------------------------------------
  logic [9:0] raw_v;
  logic [9:0] sy;
  logic       ovp_s, otp_s, von_s, voff_s, vrst_s, bo_s;
  logic       skin_s, skout_s, remhi_s, remlo_s;
  logic       ovp_ok, otp_ok;
  logic [CNT_W-1:0] ovp_tc_q, otp_tc_q, otp_blank_tc_q, rem_blank_tc_q, ar_tc_q;

  assign raw_v = {window_protect_above_high, window_protect_below_low,
                  supply_above_turn_on, supply_below_turn_off,
                  supply_below_reset, bulk_in_range_flag,
                  skip_entry_reached, skip_exit_reached,
                  remote_above_entry, remote_below_exit};

  fwo_sync #(.W(10)) u_sync (                               // RULE23
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (raw_v),
    .sync_out (sy)
  );

  assign {ovp_s, otp_s, von_s, voff_s, vrst_s, bo_s,
          skin_s, skout_s, remhi_s, remlo_s} = sy;

  // independent filters on the window edges
  fwo_filter u_ovp_filt (                                    // RULE5
    .pclk      (pclk),
    .presetn   (presetn),
    .level     (ovp_s),                                      // RULE12
    .term_cnt  (ovp_tc_q),
    .confirmed (ovp_ok)
  );

  fwo_filter u_otp_filt (                                    // RULE5
    .pclk      (pclk),
    .presetn   (presetn),
    .level     (otp_s),
    .term_cnt  (otp_tc_q),
    .confirmed (otp_ok)
  );

  // ----------------------------------------------------------------
  // straps, edges and internal flags
  // ----------------------------------------------------------------
  fwo_state_t       state_q;
  logic             strap_done_q, latch_var_q, act_on_var_q;
  logic             bo_d1_q;
  logic             first_start_q, left_off_q, skip_q, prot_q;
  logic             run_en_q;
  logic [CNT_W-1:0] otp_blank_q, rem_blank_q, ar_q;
  logic             bo_rise, bo_fall, fault_hit;
  logic             start_run, prot_set, prot_clr, skip_set, skip_clr;
  logic             off_enter, off_exit, ar_done, otp_blank_busy, rem_busy;

  // straps captured once, first edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done_q <= 1'b0;
      latch_var_q  <= 1'b0;
      act_on_var_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;                                   // RULE24
      latch_var_q  <= strap_latched;
      act_on_var_q <= strap_active_on;
    end
  end

  // edge history of the bulk flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bo_d1_q  <= 1'b0;
    end else begin
      bo_d1_q  <= bo_s;
    end
  end

  assign bo_rise        = bo_s & ~bo_d1_q;
  assign bo_fall        = ~bo_s & bo_d1_q;
  assign otp_blank_busy = (otp_blank_q != '0);
  assign rem_busy       = (rem_blank_q != '0);
  assign ar_done        = (state_q == ST_AR) && (ar_q == '0);
  // low edge ignored while startup blanking runs
  assign fault_hit      = (state_q == ST_RUN) &&
                          (ovp_ok || (otp_ok && !otp_blank_busy));  // RULE6
  // bulk flag high is the permission to run
  assign start_run      = (state_q == ST_IDLE) && von_s && bo_s &&  // RULE22
                          strap_done_q;
  // remote input acts in active-on only, not while blanked
  assign off_enter      = (state_q == ST_RUN) && act_on_var_q &&    // RULE13
                          remhi_s && !rem_busy;                     // RULE14 RULE17
  assign off_exit       = (state_q == ST_OFF) && remlo_s;           // RULE15
  assign skip_set       = (state_q == ST_RUN) && skin_s && !skip_q;
  assign skip_clr       = skip_q && skout_s;

  // protect enable set and clear events
  assign prot_set = start_run || bo_rise && (state_q == ST_RUN) ||  // RULE8
                    skip_clr;
  assign prot_clr = voff_s || bo_fall || fault_hit ||               // RULE9
                    skip_set || off_enter || (state_q != ST_RUN);

  // first start follows a reset-level supply drop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_start_q <= 1'b1;
    end else if (vrst_s) begin
      first_start_q <= 1'b1;
    end else if (start_run) begin
      first_start_q <= 1'b0;
    end
  end

  // marks a restart after a normal off-mode exit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_off_q <= 1'b0;
    end else if (off_exit) begin
      left_off_q <= 1'b1;
    end else if (start_run || ar_done || vrst_s) begin
      left_off_q <= 1'b0;
    end
  end

  // skip mode with hysteresis
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_q <= 1'b0;
    end else if (skip_set) begin
      skip_q <= 1'b1;
    end else if (skip_clr || state_q != ST_RUN) begin
      skip_q <= 1'b0;
    end
  end

  // protect enable level, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_q <= 1'b0;
    end else if (prot_set) begin
      prot_q <= 1'b1;                                         // RULE8
    end else if (prot_clr) begin
      prot_q <= 1'b0;                                         // RULE9
    end
  end

  // ----------------------------------------------------------------
  // blanking and recovery timers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      otp_blank_q <= '0;
    end else if (prot_set && !prot_q) begin
      otp_blank_q <= otp_blank_tc_q;                          // RULE6 RULE23
    end else if (!prot_q) begin
      otp_blank_q <= '0;
    end else if (otp_blank_busy) begin
      otp_blank_q <= otp_blank_q - CNT_W'(1);
    end
  end

  // remote blanking on turn-on except a normal off-mode exit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem_blank_q <= '0;
    end else if (start_run && !left_off_q) begin
      rem_blank_q <= rem_blank_tc_q;                          // RULE18 RULE19 RULE20
    end else if (state_q != ST_RUN) begin
      rem_blank_q <= '0;
    end else if (rem_busy) begin
      rem_blank_q <= rem_blank_q - CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ar_q <= '0;
    end else if (fault_hit && !latch_var_q) begin
      ar_q <= ar_tc_q;                                        // RULE4
    end else if (state_q == ST_AR && ar_q != '0) begin
      ar_q <= ar_q - CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_run) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (fault_hit) begin
            state_q <= latch_var_q ? ST_LATCH : ST_AR;        // RULE3 RULE4
          end else if (off_enter) begin
            state_q <= ST_OFF;                                // RULE14
          end else if (voff_s || !bo_s) begin
            state_q <= ST_IDLE;
          end
        end
        ST_OFF: begin
          if (off_exit) begin
            state_q <= ST_IDLE;                               // RULE15
          end
        end
        ST_AR: begin
          if (ar_done) begin
            state_q <= ST_IDLE;                               // RULE19
          end
        end
        ST_LATCH: begin
          if (vrst_s) begin
            state_q <= ST_IDLE;                               // RULE11
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_enable         <= 1'b0;
      protect_enable_signal <= 1'b0;
      sense_current_enable  <= 1'b0;
      doubled_sense_current <= 1'b0;
      remote_pull_low       <= 1'b0;
      latched_fault         <= 1'b0;
      offmode_active        <= 1'b0;
    end else begin
      // window between both edges, after filtering
      switch_enable         <= (state_q == ST_RUN) && prot_q && !skip_q &&
                               !ovp_ok && !(otp_ok && !otp_blank_busy) &&  // RULE1 RULE2
                               run_en_q && !fault_hit;                     // RULE10
      protect_enable_signal <= prot_q;
      sense_current_enable  <= prot_q;
      doubled_sense_current <= prot_q && otp_blank_busy;                   // RULE7
      remote_pull_low       <= rem_busy;                                   // RULE17
      latched_fault         <= (state_q == ST_LATCH);                      // RULE10
      offmode_active        <= (state_q == ST_OFF);
    end
  end

  // startup source cycles while not running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      self_supply_cycling <= 1'b1;
    end else if (state_q == ST_RUN) begin
      self_supply_cycling <= 1'b0;
    end else if (voff_s) begin
      self_supply_cycling <= 1'b1;                            // RULE10 RULE21
    end else if (von_s) begin
      self_supply_cycling <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // apb register file, no wait states
  // ----------------------------------------------------------------
  logic        setup, wr_now, hit;
  logic [31:0] rd_mux;

  assign setup  = psel && !penable;
  assign wr_now = psel && penable && pready && pwrite;

  always_comb begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      ADDR_CTRL:   rd_mux[CTRL_RUN_BIT] = run_en_q;
      ADDR_STATUS: rd_mux = {19'h0_0000, skip_q, left_off_q, first_start_q,
                             act_on_var_q, latch_var_q, otp_blank_busy, rem_busy,
                             ovp_ok, otp_ok, prot_q, state_q};
      ADDR_FILT:   rd_mux = {otp_tc_q, ovp_tc_q};
      ADDR_BLANK:  rd_mux = {rem_blank_tc_q, otp_blank_tc_q};
      ADDR_ARTIME: rd_mux[CNT_W-1:0] = ar_tc_q;
      default:     hit = 1'b0;
    endcase
  end

  // answer registered at setup, ready in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !hit;
      prdata  <= (setup && !pwrite && hit) ? rd_mux : 32'h0000_0000;
    end
  end

  // writable configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_en_q       <= CTRL_RUN_RST;
      ovp_tc_q       <= OVP_FILT_RST;
      otp_tc_q       <= OTP_FILT_RST;
      otp_blank_tc_q <= OTP_BLANK_RST;
      rem_blank_tc_q <= REM_BLANK_RST;
      ar_tc_q        <= AR_TIME_RST;
    end else if (wr_now) begin
      case (paddr)
        ADDR_CTRL: begin
          run_en_q <= pwdata[CTRL_RUN_BIT];
        end
        ADDR_FILT: begin
          ovp_tc_q <= pwdata[LO_LSB +: CNT_W];                // RULE23
          otp_tc_q <= pwdata[HI_LSB +: CNT_W];
        end
        ADDR_BLANK: begin
          otp_blank_tc_q <= pwdata[LO_LSB +: CNT_W];
          rem_blank_tc_q <= pwdata[HI_LSB +: CNT_W];
        end
        ADDR_ARTIME: begin
          ar_tc_q <= pwdata[LO_LSB +: CNT_W];
        end
        default: begin
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** verif/fwo_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// port checker for the sequencer
// ------------------------------------------------------------
module fwo_checker (
  // clock, reset and apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // supply level
  input wire logic        supply_below_reset,
  // control outputs
  input wire logic        switch_enable,
  input wire logic        sense_current_enable,
  input wire logic        doubled_sense_current,
  input wire logic        remote_pull_low,
  input wire logic        latched_fault,
  input wire logic        offmode_active
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // bus answer timing
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready one cycle after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  chk_error_data_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");

  // sequencer outputs
  chk_latch_no_switch: assert property (latched_fault |-> !switch_enable)
    else $error("switching while latched");
  chk_off_stops_all: assert property (
    offmode_active |-> !switch_enable && !sense_current_enable)
    else $error("activity in off-mode");
  chk_boost_in_enable: assert property (
    doubled_sense_current |-> sense_current_enable)
    else $error("doubled current without enable");
  chk_latch_holds: assert property (
    latched_fault && !$past(supply_below_reset) && !$past(supply_below_reset, 2)
    && !$past(supply_below_reset, 3) |=> latched_fault)
    else $error("latch left without reset level");
  chk_blank_no_off: assert property (remote_pull_low |-> !offmode_active)
    else $error("off-mode during remote blanking");

  // main scenarios reached
  cov_latch: cover property (latched_fault);
  cov_off: cover property (offmode_active);
  cov_blank: cover property ($rose(remote_pull_low));
  cov_err: cover property (pslverr);
endmodule
`default_nettype wire

// *** verif/fwo_offmode_partner.sv ***
`timescale 1ns/100ps
`default_nettype none
// secondary off-mode controller behind its optocoupler
module fwo_offmode_partner #(
  parameter int RISE_CYC = 2
) (
  // clock and opto command
  input  wire logic pclk,
  input  wire logic opto_active,
  input  wire logic remote_pull_low,
  // remote pin comparators
  output logic      remote_above_entry,
  output logic      remote_below_exit
);
  int rise_q = 0;
  // opto or pull-down holds the pin low, aux bias lifts it
  always_ff @(posedge pclk) begin
    if (opto_active || remote_pull_low) begin
      rise_q <= 0;
    end else if (rise_q < RISE_CYC) begin
      rise_q <= rise_q + 1;
    end
  end
  assign remote_above_entry = (rise_q == RISE_CYC);
  assign remote_below_exit  = (rise_q == 0);
endmodule
`default_nettype wire

// *** verif/fwo_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module fwo_top_tb
  import fwo_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, remote_above_entry, remote_below_exit;
  logic        window_protect_above_high = 1'b0, window_protect_below_low = 1'b0;
  logic        supply_above_turn_on = 1'b0, supply_below_turn_off = 1'b0;
  logic        supply_below_reset = 1'b0, bulk_in_range_flag = 1'b0, opto_active = 1'b1;
  logic        strap_latched = 1'b0, strap_active_on = 1'b1;
  logic        switch_enable, protect_enable_signal, sense_current_enable;
  logic        doubled_sense_current, remote_pull_low, self_supply_cycling;
  logic        latched_fault, offmode_active;
  int          n_errors = 0, tests_run = 0, cyc = 0;

  // design and far side
  fwo_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .window_protect_above_high, .window_protect_below_low,
    .supply_above_turn_on, .supply_below_turn_off, .supply_below_reset,
    .bulk_in_range_flag, .skip_entry_reached(1'b0), .skip_exit_reached(1'b0),
    .remote_above_entry, .remote_below_exit, .strap_latched, .strap_active_on,
    .switch_enable, .protect_enable_signal, .sense_current_enable,
    .doubled_sense_current, .remote_pull_low, .self_supply_cycling, .latched_fault,
    .offmode_active);
  fwo_offmode_partner far_u (.pclk, .opto_active, .remote_pull_low,
    .remote_above_entry, .remote_below_exit);

  // clock and hang guard
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic tally_and_finish;
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim);
    int n = 0;
    while (s !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, s}, {31'h0, v});
  endtask
  task automatic hold_chk(ref logic s, input logic v, input int len);
    logic bad = 1'b0;
    repeat (len) begin
      @(posedge pclk);
      if (s !== v) bad = 1'b1;
    end
    chk({31'h0, bad}, 32'h0);
  endtask
  task automatic do_reset(input logic lat);
    presetn              <= 1'b0;
    strap_latched        <= lat;
    supply_above_turn_on <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic shorten;
    apb(1'b1, ADDR_FILT, 32'h0004_0004);
    apb(1'b1, ADDR_BLANK, 32'h0008_0014);
    apb(1'b1, ADDR_ARTIME, 32'h0000_0006);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h0000_0001);
    apb(1'b0, ADDR_FILT, 32'h0);
    chk(rd, {OTP_FILT_RST, OVP_FILT_RST});
    apb(1'b0, ADDR_BLANK, 32'h0);
    chk(rd, {REM_BLANK_RST, OTP_BLANK_RST});
    apb(1'b0, ADDR_ARTIME, 32'h0);
    chk(rd, {16'h0, AR_TIME_RST});
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
    chk({31'h0, er}, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'({rd[9:8], rd[2:0]}), 32'h10);
    shorten();
    apb(1'b0, ADDR_BLANK, 32'h0);
    chk(rd, 32'h0008_0014);
  endtask
  task automatic t_start;
    bulk_in_range_flag   <= 1'b1;
    supply_above_turn_on <= 1'b1;
    wait_for(remote_pull_low, 1'b1, 10);
    wait_for(doubled_sense_current, 1'b1, 10);
    wait_for(switch_enable, 1'b1, 40);
    chk({31'h0, protect_enable_signal}, 32'h1);
    wait_for(remote_pull_low, 1'b0, 20);
    wait_for(doubled_sense_current, 1'b0, 40);
  endtask
  task automatic t_glitch;
    window_protect_above_high <= 1'b1;
    repeat (2) @(posedge pclk);
    window_protect_above_high <= 1'b0;
    window_protect_below_low  <= 1'b1;
    repeat (2) @(posedge pclk);
    window_protect_below_low <= 1'b0;
    hold_chk(switch_enable, 1'b1, 12);
  endtask
  task automatic t_recover;
    window_protect_above_high <= 1'b1;
    hold_chk(switch_enable, 1'b1, 3);
    wait_for(switch_enable, 1'b0, 12);
    @(posedge pclk);
    chk({30'h0, latched_fault, sense_current_enable}, 32'h0);
    window_protect_above_high <= 1'b0;
    wait_for(remote_pull_low, 1'b1, 30);
    wait_for(switch_enable, 1'b1, 40);
    wait_for(doubled_sense_current, 1'b0, 40);
    wait_for(remote_pull_low, 1'b0, 20);
  endtask
  task automatic t_offmode;
    opto_active <= 1'b0;
    wait_for(offmode_active, 1'b1, 20);
    chk({30'h0, switch_enable, protect_enable_signal}, 32'h0);
    supply_above_turn_on  <= 1'b0;
    supply_below_turn_off <= 1'b1;
    wait_for(self_supply_cycling, 1'b1, 10);
    supply_below_turn_off <= 1'b0;
    supply_above_turn_on  <= 1'b1;
    wait_for(self_supply_cycling, 1'b0, 10);
    chk({31'h0, offmode_active}, 32'h1);
    opto_active <= 1'b1;
    hold_chk(remote_pull_low, 1'b0, 20);
    wait_for(switch_enable, 1'b1, 30);
    chk({31'h0, protect_enable_signal}, 32'h1);
  endtask
  task automatic t_latch;
    window_protect_below_low <= 1'b1;
    supply_above_turn_on     <= 1'b1;
    repeat (8) @(posedge pclk);
    window_protect_below_low <= 1'b0;
    wait_for(switch_enable, 1'b1, 40);
    wait_for(doubled_sense_current, 1'b0, 40);
    window_protect_below_low <= 1'b1;
    wait_for(latched_fault, 1'b1, 20);
    window_protect_below_low <= 1'b0;
    hold_chk(latched_fault, 1'b1, 20);
    chk({31'h0, switch_enable}, 32'h0);
    supply_below_reset <= 1'b1;
    wait_for(latched_fault, 1'b0, 10);
    supply_below_reset <= 1'b0;
    wait_for(switch_enable, 1'b1, 40);
  endtask

  // main sequence
  initial begin
    do_reset(1'b0);
    t_regs();
    t_start();
    t_glitch();
    t_recover();
    t_offmode();
    do_reset(1'b1);
    shorten();
    t_latch();
    tally_and_finish();
  end
endmodule

bind fwo_top fwo_checker chk_u (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .prdata, .supply_below_reset, .switch_enable, .sense_current_enable,
  .doubled_sense_current, .remote_pull_low, .latched_fault, .offmode_active);
`default_nettype wire
